// File: flash_host_ctrl.sv
// Host-side controller issuing read-mode command sequences to a parallel flash
`timescale 1ns/1ps
module flash_host_ctrl (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [15:0] flash_dq_i,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe_o,
	output logic [20:0] flash_addr_o,
	output logic chip_select_a_n_o,
	output logic chip_select_b_n_o,
	output logic out_en_n_o,
	output logic write_en_n_o,
	output logic reset_powerdown_pin_n_o,
	output logic bus_x16_o
);
	import flash_host_pkg::*;

	//------------------------------------------------------------------------------
	// Helper functions
	//------------------------------------------------------------------------------

	// Query word offset to pin address; byte-wide parts see each byte twice
	function automatic logic [20:0] query_pin_addr(input logic [20:0] ofs, input logic byte_mode);
		query_pin_addr = byte_mode ? {ofs[19:0], 1'b0} : ofs;
	endfunction

	// Read source the flash takes up after a command byte
	function automatic read_mode_t mode_after(input logic [7:0] cmd, input read_mode_t cur);
		case (cmd)
			CMD_READ_ARRAY: mode_after = MODE_ARRAY;
			CMD_READ_IDENT: mode_after = MODE_IDENT;
			CMD_READ_STATUS: mode_after = MODE_STATUS;
			CMD_QUERY: mode_after = MODE_QUERY;
			CMD_MULTI_WRITE: mode_after = MODE_EXT_STATUS;
			default: mode_after = cur;
		endcase
	endfunction

	// Command byte opening each sequence other than OP_READ (no command) and OP_WRITE (sends wdata_reg)
	function automatic logic [7:0] op_command(input host_op_t op);
		case (op)
			OP_STATUS: op_command = CMD_READ_STATUS;
			OP_EXT_STATUS: op_command = CMD_MULTI_WRITE;
			OP_CLEAR: op_command = CMD_CLEAR_STATUS;
			OP_QUERY: op_command = CMD_QUERY;
			OP_IDENT: op_command = CMD_READ_IDENT;
			OP_BLOCK_STATUS: op_command = CMD_READ_STATUS;
			OP_ARRAY: op_command = CMD_READ_ARRAY;
			default: op_command = CMD_READ_ARRAY;
		endcase
	endfunction

	//------------------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------------------
	logic [7:0] rd_addr;
	logic [31:0] rd_value;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic eng_req;
	logic eng_write;
	logic [20:0] eng_addr;
	logic [15:0] eng_wdata;
	logic eng_done;
	logic [15:0] eng_rdata;
	logic chip_sel_n;
	logic [15:0] rd_masked;

	seq_state_t state, next_state;
	host_op_t op, next_op;
	read_mode_t read_mode, next_read_mode;
	logic [20:0] addr_reg, next_addr_reg;
	logic [15:0] wdata_reg, next_wdata_reg;
	logic [15:0] rdata_reg, next_rdata_reg;
	logic byte_mode, next_byte_mode;
	logic powerdown, next_powerdown;
	logic done_flag, next_done_flag;
	logic refused_flag, next_refused_flag;
	logic timeout_flag, next_timeout_flag;
	logic ready_seen, next_ready_seen;
	logic [7:0] poll_cnt, next_poll_cnt;
	logic go;
	logic go_refused;
	logic finish;
	logic refuse_evt;
	logic timeout_evt;

	//------------------------------------------------------------------------------
	// Bus slave and flash cycle engine
	//------------------------------------------------------------------------------
	ahb_lite_reg_port u_bus (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hready_i(hready_i),
		.hwdata_i(hwdata_i),
		.rd_value_i(rd_value),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.rd_addr_o(rd_addr),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data)
	);

	flash_cycle_engine u_cycle (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.req_i(eng_req),
		.is_write_i(eng_write),
		.addr_i(eng_addr),
		.wdata_i(eng_wdata),
		.flash_dq_i(flash_dq_i),
		.done_o(eng_done),
		.rdata_o(eng_rdata),
		.flash_addr_o(flash_addr_o),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe_o(flash_dq_oe_o),
		.chip_sel_n_o(chip_sel_n),
		.out_en_n_o(out_en_n_o),
		.write_en_n_o(write_en_n_o)
	);

	// Both chip selects move together; the part is enabled only with both low
	assign chip_select_a_n_o = chip_sel_n;
	assign chip_select_b_n_o = chip_sel_n;
	// reset pin high
	// Pin only drops under software power-down, never while a sequence runs
	assign reset_powerdown_pin_n_o = !powerdown;
	assign bus_x16_o = !byte_mode;

	// upper byte floats
	// Byte-wide reads discard the undriven upper lines
	assign rd_masked = byte_mode ? {8'h00, eng_rdata[7:0]} : eng_rdata;

	//------------------------------------------------------------------------------
	// Register read mux
	//------------------------------------------------------------------------------
	always_comb begin
		rd_value = 32'h00000000;
		case (rd_addr)
			REG_CTRL: begin
				rd_value[CTRL_OP_MSB:CTRL_OP_LSB] = op;
				rd_value[CTRL_BYTE_MODE_BIT] = byte_mode;
				rd_value[CTRL_POWERDOWN_BIT] = powerdown;
			end
			REG_ADDR: rd_value = {11'h000, addr_reg};
			REG_WDATA: rd_value = {16'h0000, wdata_reg};
			REG_RDATA: rd_value = {16'h0000, rdata_reg};
			REG_STATUS: begin
				rd_value[STAT_BUSY_BIT] = (state != SEQ_IDLE);
				rd_value[STAT_DONE_BIT] = done_flag;
				rd_value[STAT_REFUSED_BIT] = refused_flag;
				rd_value[STAT_TIMEOUT_BIT] = timeout_flag;
				rd_value[STAT_READY_BIT] = ready_seen;
				rd_value[STAT_MODE_MSB:STAT_MODE_LSB] = read_mode;
			end
			default: rd_value = 32'h00000000;
		endcase
	end

	// Start request; refused while busy or powered down
	assign go = wr_en && (wr_addr == REG_CTRL) && wr_data[CTRL_START_BIT];
	assign go_refused = go && ((state != SEQ_IDLE) || powerdown || wr_data[CTRL_POWERDOWN_BIT]);

	//------------------------------------------------------------------------------
	// Engine request decode
	//------------------------------------------------------------------------------
	always_comb begin
		eng_req = 1'b0;
		eng_write = 1'b0;
		eng_addr = addr_reg;
		eng_wdata = 16'h0000;
		case (state)
			SEQ_CMD1: begin
				eng_req = 1'b1;
				eng_write = 1'b1;
				eng_wdata = (op == OP_WRITE) ? wdata_reg : {8'h00, op_command(op)};
			end
			SEQ_READ1: begin
				eng_req = 1'b1;
				eng_addr = (op == OP_QUERY) ? query_pin_addr(addr_reg, byte_mode) : addr_reg;
			end
			SEQ_CMD2: begin
				eng_req = 1'b1;
				eng_write = 1'b1;
				eng_wdata = {8'h00, CMD_QUERY};
			end
			SEQ_READ2: begin
				eng_req = 1'b1;
				eng_addr = query_pin_addr(addr_reg + QUERY_BLOCK_STATUS_OFS, byte_mode);
			end
			default: begin
				eng_req = 1'b0;
			end
		endcase
	end

	//------------------------------------------------------------------------------
	// Sequencer next state
	//------------------------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_op = op;
		next_read_mode = read_mode;
		next_rdata_reg = rdata_reg;
		next_ready_seen = ready_seen;
		next_poll_cnt = poll_cnt;
		finish = 1'b0;
		timeout_evt = 1'b0;
		case (state)
			SEQ_IDLE: begin
				if (go && !go_refused) begin
					next_op = host_op_t'(wr_data[CTRL_OP_MSB:CTRL_OP_LSB]);
					next_poll_cnt = 8'h00;
					next_state = (next_op == OP_READ) ? SEQ_READ1 : SEQ_CMD1;
				end
			end
			SEQ_CMD1: begin
				if (eng_done) begin
					next_read_mode = mode_after(eng_wdata[7:0], read_mode);
					if (op == OP_WRITE || op == OP_CLEAR) begin
						next_state = SEQ_IDLE;
						finish = 1'b1;
					end else begin
						next_state = SEQ_READ1;
					end
				end
			end
			SEQ_READ1: begin
				if (eng_done) begin
					next_rdata_reg = rd_masked;
					if (read_mode == MODE_STATUS) begin
						next_ready_seen = rd_masked[READY_FLAG_BIT];
					end
					if (op == OP_BLOCK_STATUS) begin
						// wait for ready
						// Each poll is a fresh read cycle so the status latch reloads
						if (rd_masked[READY_FLAG_BIT]) begin
							next_state = SEQ_CMD2;
						end else if (poll_cnt == POLL_LIMIT) begin
							next_state = SEQ_IDLE;
							finish = 1'b1;
							timeout_evt = 1'b1;
						end else begin
							next_poll_cnt = poll_cnt + 8'h01;
						end
					end else begin
						next_state = SEQ_IDLE;
						finish = 1'b1;
					end
				end
			end
			SEQ_CMD2: begin
				if (eng_done) begin
					next_read_mode = MODE_QUERY;
					next_state = SEQ_READ2;
				end
			end
			SEQ_READ2: begin
				if (eng_done) begin
					next_rdata_reg = rd_masked;
					next_state = SEQ_IDLE;
					finish = 1'b1;
				end
			end
			default: begin
				next_state = SEQ_IDLE;
			end
		endcase
		// array mode after wake
		// Leaving power-down puts the flash back in array reads by itself
		if (powerdown && !next_powerdown) begin
			next_read_mode = MODE_ARRAY;
		end
	end

	//------------------------------------------------------------------------------
	// Software registers and sticky flags
	//------------------------------------------------------------------------------
	// refresh by reissue
	// Extended status op always rewrites the command before reading
	assign refuse_evt = go_refused;

	always_comb begin
		next_addr_reg = addr_reg;
		next_wdata_reg = wdata_reg;
		next_byte_mode = byte_mode;
		next_powerdown = powerdown;
		next_done_flag = done_flag;
		next_refused_flag = refused_flag;
		next_timeout_flag = timeout_flag;
		if (wr_en) begin
			case (wr_addr)
				REG_ADDR: next_addr_reg = wr_data[20:0];
				REG_WDATA: next_wdata_reg = wr_data[15:0];
				REG_CTRL: begin
					// Mode pins must not change under a running cycle
					if (state == SEQ_IDLE) begin
						next_byte_mode = wr_data[CTRL_BYTE_MODE_BIT];
						next_powerdown = wr_data[CTRL_POWERDOWN_BIT];
					end
				end
				REG_STATUS: begin
					next_done_flag = done_flag && !wr_data[STAT_DONE_BIT];
					next_refused_flag = refused_flag && !wr_data[STAT_REFUSED_BIT];
					next_timeout_flag = timeout_flag && !wr_data[STAT_TIMEOUT_BIT];
				end
				default: begin
					next_addr_reg = addr_reg;
				end
			endcase
		end
		// Set wins over a clear in the same cycle
		if (finish) begin
			next_done_flag = 1'b1;
		end
		if (refuse_evt) begin
			next_refused_flag = 1'b1;
		end
		if (timeout_evt) begin
			next_timeout_flag = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= SEQ_IDLE;
			op <= OP_WRITE;
			read_mode <= MODE_ARRAY;
			addr_reg <= ADDR_RESET;
			wdata_reg <= 16'h0000;
			rdata_reg <= RDATA_RESET;
			byte_mode <= 1'b0;
			powerdown <= 1'b0;
			done_flag <= 1'b0;
			refused_flag <= 1'b0;
			timeout_flag <= 1'b0;
			ready_seen <= 1'b0;
			poll_cnt <= 8'h00;
		end else if (ce_i) begin
			state <= next_state;
			op <= next_op;
			read_mode <= next_read_mode;
			addr_reg <= next_addr_reg;
			wdata_reg <= next_wdata_reg;
			rdata_reg <= next_rdata_reg;
			byte_mode <= next_byte_mode;
			powerdown <= next_powerdown;
			done_flag <= next_done_flag;
			refused_flag <= next_refused_flag;
			timeout_flag <= next_timeout_flag;
			ready_seen <= next_ready_seen;
			poll_cnt <= next_poll_cnt;
		end
	end
endmodule

// File: flash_host_pkg.sv
// Constants, types and register map for the parallel flash host controller
//------------------------------------------------------------------------------
// Function
// - Read-mode commands work at any supply; reset pin must stay high meanwhile.
// - Identifier mode lasts until the host writes another valid command.
// - Status latches on falling strobe; host raises strobe before next read.
// - Extended status latches on last falling strobe; host reissues command to refresh.
// - Block status valid only while ready flag is 1; erase failure marks block.
//------------------------------------------------------------------------------
package flash_host_pkg;

	//------------------------------------------------------------------------------
	// Register map, byte addresses on the AHB-Lite port
	//------------------------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// Control register fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_OP_MSB = 4;
	localparam int CTRL_BYTE_MODE_BIT = 5;
	localparam int CTRL_POWERDOWN_BIT = 6;

	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_REFUSED_BIT = 2;
	localparam int STAT_TIMEOUT_BIT = 3;
	localparam int STAT_READY_BIT = 4;
	localparam int STAT_MODE_LSB = 8;
	localparam int STAT_MODE_MSB = 10;

	// Reset values
	localparam logic [15:0] RDATA_RESET = 16'h0000;
	localparam logic [20:0] ADDR_RESET = 21'h000000;

	//------------------------------------------------------------------------------
	// Flash command bytes and query layout
	//------------------------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_IDENT = 8'h90;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_MULTI_WRITE = 8'hE8;
	localparam logic [20:0] QUERY_BLOCK_STATUS_OFS = 21'h000002;
	localparam int READY_FLAG_BIT = 7;
	localparam logic [7:0] POLL_LIMIT = 8'hFF;

	//------------------------------------------------------------------------------
	// Bus cycle timing, 25 MHz system clock
	//------------------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int ADDR_SETUP_NS = 10;
	localparam int STROBE_LOW_NS = 60;
	localparam int READ_ACCESS_NS = 100;
	localparam int RECOVER_NS = 30;
	localparam logic [3:0] ADDR_SETUP_CYC = 4'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] STROBE_LOW_CYC = 4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] READ_ACCESS_CYC = 4'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] RECOVER_CYC = 4'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	//------------------------------------------------------------------------------
	// Types
	//------------------------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_WRITE = 4'h0,
		OP_READ = 4'h1,
		OP_STATUS = 4'h2,
		OP_EXT_STATUS = 4'h3,
		OP_CLEAR = 4'h4,
		OP_QUERY = 4'h5,
		OP_IDENT = 4'h6,
		OP_BLOCK_STATUS = 4'h7,
		OP_ARRAY = 4'h8
	} host_op_t;

	typedef enum logic [2:0] {
		MODE_ARRAY = 3'h0,
		MODE_IDENT = 3'h1,
		MODE_STATUS = 3'h2,
		MODE_EXT_STATUS = 3'h3,
		MODE_QUERY = 3'h4
	} read_mode_t;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_CMD1 = 3'b001,
		SEQ_READ1 = 3'b011,
		SEQ_CMD2 = 3'b010,
		SEQ_READ2 = 3'b110
	} seq_state_t;

	typedef enum logic [2:0] {
		CYC_IDLE = 3'b000,
		CYC_SETUP = 3'b001,
		CYC_STROBE = 3'b011,
		CYC_HOLD = 3'b010,
		CYC_RECOVER = 3'b110
	} cycle_state_t;

endpackage

// File: ahb_lite_reg_port.sv
// AHB-Lite slave front end for the controller's own registers
`timescale 1ns/1ps
module ahb_lite_reg_port (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	input wire logic [31:0] rd_value_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [7:0] rd_addr_o,
	output logic wr_en_o,
	output logic [7:0] wr_addr_o,
	output logic [31:0] wr_data_o
);
	import flash_host_pkg::*;

	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] hrdata;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic take;

	// Word transfers only; other sizes pass with OKAY and no effect
	assign take = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'b010);

	// Frozen clock enable stretches the data phase instead of dropping it
	assign hreadyout_o = ce_i;
	assign hresp_o = 1'b0;
	assign rd_addr_o = haddr_i[7:0];
	assign hrdata_o = hrdata;
	assign wr_en_o = wr_pend && ce_i;
	assign wr_addr_o = wr_addr;
	assign wr_data_o = hwdata_i;

	// Address phase capture; read data is fetched early so it is a flop output
	always_comb begin
		next_wr_pend = take && hwrite_i;
		next_wr_addr = take ? haddr_i[7:0] : wr_addr;
		next_hrdata = (take && !hwrite_i) ? rd_value_i : hrdata;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h00000000;
		end else if (ce_i) begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
		end
	end
endmodule

// File: flash_cycle_engine.sv
// One asynchronous flash bus cycle, read or write, timed in system clocks
`timescale 1ns/1ps
module flash_cycle_engine (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic req_i,
	input wire logic is_write_i,
	input wire logic [20:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [15:0] flash_dq_i,
	output logic done_o,
	output logic [15:0] rdata_o,
	output logic [20:0] flash_addr_o,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe_o,
	output logic chip_sel_n_o,
	output logic out_en_n_o,
	output logic write_en_n_o
);
	import flash_host_pkg::*;

	cycle_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic wr, next_wr;
	logic [20:0] addr, next_addr;
	logic [15:0] wdata, next_wdata;
	logic [15:0] rdata, next_rdata;

	// Pins decode the registered state only
	assign flash_addr_o = addr;
	assign flash_dq_o = wdata;
	assign flash_dq_oe_o = wr && (state != CYC_IDLE) && (state != CYC_RECOVER);
	assign chip_sel_n_o = !((state == CYC_STROBE) || (state == CYC_HOLD && wr));
	assign out_en_n_o = !(state == CYC_STROBE && !wr);
	assign write_en_n_o = !(state == CYC_STROBE && wr);
	assign rdata_o = rdata;
	assign done_o = (state == CYC_RECOVER) && (cnt == 4'h0);

	// Cycle sequencing: setup, strobe, hold, recovery
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_wr = wr;
		next_addr = addr;
		next_wdata = wdata;
		next_rdata = rdata;
		case (state)
			CYC_IDLE: begin
				if (req_i) begin
					next_state = CYC_SETUP;
					next_cnt = ADDR_SETUP_CYC - 4'h1;
					next_wr = is_write_i;
					next_addr = addr_i;
					next_wdata = wdata_i;
				end
			end
			CYC_SETUP: begin
				if (cnt == 4'h0) begin
					next_state = CYC_STROBE;
					next_cnt = (wr ? STROBE_LOW_CYC : READ_ACCESS_CYC) - 4'h1;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			CYC_STROBE: begin
				if (cnt == 4'h0) begin
					next_state = CYC_HOLD;
					// Sample before the strobe rises; the latch holds across it
					if (!wr) begin
						next_rdata = flash_dq_i;
					end
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			CYC_HOLD: begin
				// write strobe first
				// Write-enable rises a cycle before chip-select so it is the capturing edge
				next_state = CYC_RECOVER;
				next_cnt = RECOVER_CYC - 4'h1;
			end
			CYC_RECOVER: begin
				if (cnt == 4'h0) begin
					next_state = CYC_IDLE;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			default: begin
				next_state = CYC_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= CYC_IDLE;
			cnt <= 4'h0;
			wr <= 1'b0;
			addr <= ADDR_RESET;
			wdata <= 16'h0000;
			rdata <= RDATA_RESET;
		end else if (ce_i) begin
			state <= next_state;
			cnt <= next_cnt;
			wr <= next_wr;
			addr <= next_addr;
			wdata <= next_wdata;
			rdata <= next_rdata;
		end
	end
endmodule

// File: flash_dev_model.sv
// Behavioural parallel flash that answers the read-mode commands
`timescale 1ns/1ps
module flash_dev_model #(
	parameter logic [7:0] MAKER = 8'h11, // Arbitrary value
	parameter logic [7:0] DEVID = 8'h22, // Arbitrary value
	parameter logic [7:0] SETID = 8'h33 // Arbitrary value
) (
	input wire logic [20:0] a_i,
	input wire logic [15:0] d_i,
	input wire logic cs_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic rp_n_i,
	input wire logic x16_i,
	output logic [15:0] q_o,
	output logic drv_o
);
	localparam logic [7:0] BLOCK_LOCK_ERASE_STATUS = 8'h03;
	logic [2:0] mode = 3'h0;
	logic [7:0] err = 8'h3A;
	logic [7:0] lat = 8'h00;
	int n = 0;
	// byte wide drops the lowest address bit
	wire [20:0] qa = x16_i ? a_i : a_i >> 1;
	// no internal operation ever runs here, so FFH is never ignored
	always @(posedge we_n_i or negedge rp_n_i) begin
		if (!rp_n_i)
			mode = 3'h0;
		else if (!cs_n_i)
			case (d_i[7:0])
				8'hFF: mode = 3'h0;
				8'h90: mode = 3'h1;
				8'h70: mode = 3'h2;
				8'hE8: mode = 3'h3;
				8'h98: mode = 3'h4;
				8'h50: err = 8'h00;
				default: ;
			endcase
	end
	// latched at falling strobe, ready from third poll
	always @(negedge oe_n_i) begin
		lat = {n > 1, 1'b0, err[5:0]};
		if (mode == 3'h2)
			n++;
	end
	always_comb begin
		case (mode)
			3'h0: q_o = a_i[15:0] ^ 16'hA5C3;
			3'h1: q_o = a_i[14:0] < 2 ? MAKER : a_i[14:0] < 4 ? DEVID : a_i[14:0] < 6 ? BLOCK_LOCK_ERASE_STATUS : 0;
			3'h2: q_o = 16'(lat);
			3'h3: q_o = 16'h0080;
			default: case (qa)
				21'h10: q_o = 16'h0051;
				21'h11: q_o = 16'h0052;
				21'h12: q_o = 16'h0059;
				21'h13: q_o = 16'(SETID);
				21'h15: q_o = 16'h0031;
				default: q_o = qa[14:0] == 2 ? 16'(BLOCK_LOCK_ERASE_STATUS) : 16'h0000;
			endcase
		endcase
	end
	// no answer while held in power-down
	assign drv_o = rp_n_i && !cs_n_i && !oe_n_i;
endmodule

// File: flash_host_ctrl_asserts.sv
// Checker for the flash pin strobes of the host controller
`timescale 1ns/1ps
module flash_host_ctrl_asserts (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic hresp_o,
	input wire logic flash_dq_oe_o,
	input wire logic chip_select_a_n_o,
	input wire logic chip_select_b_n_o,
	input wire logic out_en_n_o,
	input wire logic write_en_n_o,
	input wire logic reset_powerdown_pin_n_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence wr_pulse;
		!write_en_n_o [*2] ##1 write_en_n_o;
	endsequence
	sequence rd_pulse;
		!out_en_n_o [*3] ##1 out_en_n_o;
	endsequence
	a_sel_twins: assert property (chip_select_a_n_o == chip_select_b_n_o) else $error("selects differ");
	a_write_len: assert property ($fell(write_en_n_o) |-> wr_pulse) else $error("write strobe");
	a_read_len: assert property ($fell(out_en_n_o) |-> rd_pulse) else $error("read strobe");
	a_we_first: assert property ($rose(write_en_n_o) |-> !chip_select_a_n_o) else $error("we order");
	a_write_data: assert property (!write_en_n_o |-> flash_dq_oe_o && out_en_n_o) else $error("wr data");
	a_read_bus: assert property (!out_en_n_o |-> !flash_dq_oe_o && !chip_select_a_n_o) else $error("rd bus");
	a_read_gap: assert property ($rose(out_en_n_o) |-> (out_en_n_o && chip_select_a_n_o) [*3]) else $error("gap");
	a_rp_high: assert property (!chip_select_a_n_o |-> reset_powerdown_pin_n_o) else $error("rp low");
	a_bus_okay: assert property (hresp_o == 1'b0) else $error("resp");
endmodule
bind flash_host_ctrl flash_host_ctrl_asserts chk (.*);

// File: flash_host_ctrl_tb.sv
// Register-level bench for the flash host controller
`timescale 1ns/1ps
module flash_host_ctrl_tb;
	import flash_host_pkg::*;
	localparam logic [7:0] MK = 8'h11; // Arbitrary value
	localparam logic [7:0] DV = 8'h22; // Arbitrary value
	localparam logic [7:0] ST = 8'h33; // Arbitrary value
	logic clk = 0, rst = 1, hwr = 0, bm = 0, drv, rdy, dq_oe, cs_a, oe, we, rp, x16;
	logic [1:0] htr = 0;
	logic [31:0] ha = 0, hwd = 0, hrd, q;
	logic [15:0] dq_o, dq_d, r, last = 0;
	logic [20:0] fa;
	logic [7:0] qry [11] = '{8'h51, 8'h52, 8'h59, ST, 0, 8'h31, 0, 0, 0, 0, 0};
	int mismatches = 0, comparisons = 0;
	// Released data lines show the inverse of the last value the flash drove
	wire [15:0] dq_i = drv ? dq_d : dq_oe ? dq_o : ~last;
	flash_host_ctrl DUT (.sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .hsel_i(1'b1), .haddr_i(ha),
		.htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'b010), .hready_i(rdy), .hwdata_i(hwd), .hrdata_o(hrd),
		.hreadyout_o(rdy), .hresp_o(), .flash_dq_i(dq_i), .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe),
		.flash_addr_o(fa), .chip_select_a_n_o(cs_a), .chip_select_b_n_o(), .out_en_n_o(oe),
		.write_en_n_o(we), .reset_powerdown_pin_n_o(rp), .bus_x16_o(x16));
	flash_dev_model #(.MAKER(MK), .DEVID(DV), .SETID(ST)) dev (.a_i(fa), .d_i(dq_o), .cs_n_i(cs_a),
		.oe_n_i(oe), .we_n_i(we), .rp_n_i(rp), .x16_i(x16), .q_o(dq_d), .drv_o(drv));
	always @(posedge clk) if (drv) last <= dq_d;
	initial forever #20 clk = ~clk;
	// One AHB-Lite single word transfer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		ha <= {24'h0, a};
		hwr <= w;
		htr <= 2'b10;
		do @(posedge clk); while (rdy !== 1'b1);
		htr <= 2'b00;
		hwd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		q = hrd;
	endtask
	// Launch one operation, wait for done, fetch read data
	task automatic run(input logic [3:0] o, input logic [20:0] a);
		xfer(1, REG_ADDR, 32'(a));
		xfer(1, REG_CTRL, 32'({bm, o, 1'b1}));
		q = 0;
		repeat (400) if (q[STAT_DONE_BIT] !== 1'b1) xfer(0, REG_STATUS, 0);
		// A sequence that never finishes counts against the run
		chk(q[STAT_DONE_BIT], 1);
		xfer(1, REG_STATUS, 32'h2);
		xfer(0, REG_RDATA, 0);
		r = q[15:0];
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#2000000;
		mismatches++;
		finish_test;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		xfer(0, REG_STATUS, 0);
		chk(q[10:8], 0);
		run(OP_READ, 21'h123);
		chk(r, 16'h0123 ^ 16'hA5C3);
		for (int i = 0; i < 6; i++) begin
			run(OP_IDENT, 21'(i));
			chk(r, i < 2 ? MK : i < 4 ? DV : 8'h03);
		end
		run(OP_READ, 21'h3);
		chk(r, DV);
		run(OP_STATUS, 0);
		chk(r, 16'h003A);
		run(OP_READ, 0);
		chk(r, 16'h003A);
		run(OP_EXT_STATUS, 0);
		chk(r, 16'h0080);
		run(OP_CLEAR, 0);
		run(OP_STATUS, 0);
		chk(r, 16'h0080);
		foreach (qry[i]) begin
			run(OP_QUERY, 21'h10 + 21'(i));
			chk(r, qry[i]);
		end
		run(OP_QUERY, 21'h2F0);
		chk(r, 0);
		run(OP_QUERY, 21'h8002);
		chk(r, 8'h03);
		bm = 1;
		run(OP_QUERY, 21'h11);
		chk(r, 16'h0052);
		run(OP_READ, 21'h23);
		chk(r, 16'h0052);
		bm = 0;
		run(OP_BLOCK_STATUS, 21'h10000);
		chk(r, 8'h03);
		run(OP_ARRAY, 21'h77);
		chk(r, 16'h0077 ^ 16'hA5C3);
		// Raw command write of 90H: tracked mode and data source follow it
		xfer(1, REG_WDATA, 32'h90);
		run(OP_WRITE, 0);
		xfer(0, REG_STATUS, 0);
		chk(q[10:8], 1);
		run(OP_READ, 21'h1);
		chk(r, MK);
		run(OP_IDENT, 0);
		xfer(1, REG_CTRL, 32'h41);
		xfer(0, REG_STATUS, 0);
		chk(q[STAT_REFUSED_BIT], 1);
		xfer(0, 8'h20, 0);
		chk(q, 0);
		// Wake first; a start with power-down still set would be refused
		xfer(1, REG_CTRL, 32'h0);
		xfer(0, REG_STATUS, 0);
		chk(q[10:8], 0);
		run(OP_READ, 21'h5);
		chk(r, 16'h0005 ^ 16'hA5C3);
		finish_test;
	end
endmodule
